/* rtl/cxd_pkg.sv */
// Overview of operation
// - mode pin picks speed, slope, standby
// - watch rxd in standby, then wake
// - bit time at most 62.5 us
// - bus rate at most 1 Mb/s
package cxd_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ        = 25_000_000;
    localparam int unsigned MAX_BIT_NS    = 62_500;
    localparam int unsigned MIN_BIT_NS    = 1_000;
    localparam int unsigned CLK_NS        = 1_000_000_000 / CLK_HZ;
    localparam int unsigned MAX_BIT_CYC   = MAX_BIT_NS / CLK_NS;
    localparam int unsigned MIN_BIT_CYC   = (MIN_BIT_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned TRIP_NS       = 1_250_000;
    localparam int unsigned TRIP_CYC      = TRIP_NS / CLK_NS;
    localparam logic [15:0] DIV_RESET     = 16'h0019;
    // divider holds cycles per bit minus one
    localparam logic [15:0] DIV_MAX       = 16'(MAX_BIT_CYC - 1);
    localparam logic [15:0] DIV_MIN       = 16'(MIN_BIT_CYC);

    // ------------------------------------------------------------
    // register map of the controller
    // ------------------------------------------------------------
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_TXDATA = 4'h1;
    localparam logic [3:0] REG_STATUS = 4'h2;
    localparam logic [3:0] REG_DIV    = 4'h3;
    localparam logic [3:0] REG_RXDATA = 4'h4;
    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam int unsigned CTRL_GO_BIT   = 2;
    localparam int unsigned ST_BUSY_BIT   = 0;
    localparam int unsigned ST_ACT_BIT    = 1;
    localparam int unsigned ST_RX_BIT     = 2;
    localparam logic [1:0]  MODE_RESET    = 2'h2;

    typedef enum logic [1:0] {
        CXD_MODE_FAST  = 2'h0,
        CXD_MODE_SLOPE = 2'h1,
        CXD_MODE_STBY  = 2'h2
    } cxd_mode_t;

    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } cxd_bus_req_t;

    typedef struct packed {
        logic txd;
        logic mode_fast;
        logic mode_slope;
    } cxd_pins_t;
endpackage : cxd_pkg

/* rtl/cxd_host.sv */
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
module cxd_host (
    input  wire logic                  clk_i,
    input  wire logic                  nrst_i,
    input  wire cxd_pkg::cxd_bus_req_t bus_i,
    output logic [31:0]                rdata_o,
    input  wire logic                  rxd_i,
    output cxd_pkg::cxd_pins_t         pins_o
);
    import cxd_pkg::*;

    // ------------------------------------------------------------
    // rxd synchroniser
    // ------------------------------------------------------------
    logic rxd_s1_r;
    logic rxd_s2_r;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rxd_s1_r <= 1'b1;
            rxd_s2_r <= 1'b1;
        end else begin
            rxd_s1_r <= rxd_i;
            rxd_s2_r <= rxd_s1_r;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    cxd_mode_t   mode_r;
    logic [15:0] div_r;
    logic [7:0]  txbuf_r;
    logic [7:0]  rxbuf_r;
    logic        busy_r;
    logic        act_r;
    logic [3:0]  bit_r;
    logic [15:0] cnt_r;
    logic        txd_r;
    logic [31:0] rdata_r;
    logic        go;
    logic        tick;
    logic [15:0] div_w;

    assign go   = bus_i.wr && bus_i.addr == REG_CTRL && bus_i.wdata[CTRL_GO_BIT];
    assign tick = busy_r && cnt_r == 16'h0000;
    // clamp keeps the bit time inside the transceiver's legal window
    // whole word compared so an oversized write clamps high, not wraps low
    assign div_w = bus_i.wdata > {16'h0000, DIV_MAX} ? DIV_MAX :
                   (bus_i.wdata[15:0] < DIV_MIN ? DIV_MIN :
                    bus_i.wdata[15:0]);

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mode_r  <= cxd_mode_t'(MODE_RESET);
            div_r   <= DIV_RESET;
            txbuf_r <= 8'hFF;
        end else if (bus_i.wr) begin
            case (bus_i.addr)
                REG_CTRL: begin
                    // mode changes are ignored mid-frame, but a standby write carrying go while idle in fast or slope mode starts a byte in standby
                    if (!busy_r && bus_i.wdata[CTRL_MODE_LSB +: 2] != 2'h3) begin
                        mode_r <= cxd_mode_t'(bus_i.wdata[CTRL_MODE_LSB +: 2]);
                    end
                end
                REG_DIV:    div_r   <= div_w;
                REG_TXDATA: txbuf_r <= bus_i.wdata[7:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // serialiser: start bit low, 8 data bits lsb first, stop high
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            busy_r  <= 1'b0;
            bit_r   <= 4'h0;
            cnt_r   <= 16'h0000;
            txd_r   <= 1'b1;
            rxbuf_r <= 8'hFF;
        end else if (go && !busy_r && mode_r != CXD_MODE_STBY) begin
            busy_r <= 1'b1;
            bit_r  <= 4'h0;
            cnt_r  <= div_r;
            txd_r  <= 1'b0;
        end else if (tick) begin
            cnt_r <= div_r;
            if (bit_r != 4'h0 && bit_r != 4'h9) begin
                rxbuf_r <= {rxd_s2_r, rxbuf_r[7:1]};
            end
            if (bit_r == 4'h9) begin
                busy_r <= 1'b0;
                txd_r  <= 1'b1;
            end else begin
                bit_r <= bit_r + 4'h1;
                // at most 9 low bits at a clamped bit time stays under the timeout
                txd_r <= (bit_r == 4'h8) ? 1'b1 : txbuf_r[bit_r[2:0]];
            end
        end else if (busy_r) begin
            cnt_r <= cnt_r - 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // activity seen while in standby, cleared on status read
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            act_r <= 1'b0;
        end else if (mode_r == CXD_MODE_STBY && !rxd_s2_r) begin
            act_r <= 1'b1;
        end else if (bus_i.rd && bus_i.addr == REG_STATUS) begin
            act_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // read port and pins
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_r <= 32'h0000_0000;
        end else if (bus_i.rd) begin
            case (bus_i.addr)
                REG_CTRL:   rdata_r <= {30'h0, mode_r};
                REG_TXDATA: rdata_r <= {24'h0, txbuf_r};
                REG_STATUS: rdata_r <= {29'h0, rxd_s2_r, act_r, busy_r};
                REG_DIV:    rdata_r <= {16'h0, div_r};
                REG_RXDATA: rdata_r <= {24'h0, rxbuf_r};
                default:    rdata_r <= 32'h0000_0000;
            endcase
        end else begin
            rdata_r <= 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pins_o <= '{txd: 1'b1, mode_fast: 1'b0, mode_slope: 1'b0};
        end else begin
            pins_o.txd        <= txd_r;
            pins_o.mode_fast  <= mode_r == CXD_MODE_FAST;
            pins_o.mode_slope <= mode_r == CXD_MODE_SLOPE;
        end
    end

    assign rdata_o = rdata_r;
endmodule : cxd_host

/* bench/cxd_host_sva.sv */
`timescale 1ns/1ns
module cxd_host_sva (
    input wire logic               clk_i,
    input wire logic               nrst_i,
    input wire cxd_pkg::cxd_pins_t pins_o
);
    import cxd_pkg::*;
    logic [15:0] low_r;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // length of the current dominant run on txd
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) low_r <= 16'h0000;
        else low_r <= pins_o.txd ? 16'h0000 : low_r + 16'h0001;
    end
    chk_mode_legal: assert property (!(pins_o.mode_fast && pins_o.mode_slope))
        else $error("both mode requests high");
    chk_stby_quiet: assert property (!pins_o.mode_fast && !pins_o.mode_slope |-> pins_o.txd)
        else $error("txd dominant in standby");
    chk_no_stuck: assert property (low_r < 16'(TRIP_CYC))
        else $error("dominant run too long");
    chk_min_bit: assert property ($rose(pins_o.txd) |-> low_r >= 16'(MIN_BIT_CYC))
        else $error("dominant bit too short");
    cover property (pins_o.mode_fast);
    cover property (pins_o.mode_slope);
    cover property ($fell(pins_o.txd));
endmodule : cxd_host_sva
bind cxd_host cxd_host_sva i_cxd_host_sva (.clk_i(clk_i), .nrst_i(nrst_i), .pins_o(pins_o));

/* bench/cxd_xcvr_model.sv */
`timescale 1ns/1ns
module cxd_xcvr_model (
    input  wire logic clk_i,
    input  wire logic txd_i,
    input  wire logic mode_fast_i,
    input  wire logic mode_slope_i,
    input  wire logic vdd_ok_i,
    input  wire logic hot_i,
    input  wire logic other_dom_i,
    output logic      bus_dom_o,
    output logic      rxd_o
);
    import cxd_pkg::*;
    int   low_r = 0;
    logic trip_r = 1'b0;
    logic arm_r = 1'b0;
    logic tx_hi;
    logic en;
    assign tx_hi = (txd_i !== 1'b0);
    always @(posedge clk_i) begin
        low_r <= tx_hi ? 0 : low_r + 1;
        trip_r <= !tx_hi && (trip_r || low_r >= TRIP_CYC);
        arm_r <= vdd_ok_i && (arm_r || tx_hi);
    end
    // both requests low means the mode pin sits high
    assign en = (mode_fast_i || mode_slope_i) && !trip_r && arm_r && !hot_i;
    assign bus_dom_o = (en && !tx_hi) || other_dom_i;
    assign rxd_o = !bus_dom_o;
endmodule : cxd_xcvr_model

/* bench/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
    import cxd_pkg::*;
    logic         clk_i = 1'b0;
    logic         nrst_i = 1'b0;
    logic         rxd, dom, hot = 1'b0, oth = 1'b0, vok = 1'b0;
    logic [31:0]  rdata, d;
    cxd_bus_req_t bus = '0;
    cxd_pins_t    pins;
    int           miscompares = 0, n_checks = 0, cyc = 0, i;
    always #20 clk_i = ~clk_i;
    cxd_host i_cxd_host (.clk_i(clk_i), .nrst_i(nrst_i), .bus_i(bus), .rdata_o(rdata),
        .rxd_i(rxd), .pins_o(pins));
    cxd_xcvr_model i_cxd_xcvr_model (.clk_i(clk_i), .txd_i(pins.txd), .mode_fast_i(pins.mode_fast),
        .mode_slope_i(pins.mode_slope), .vdd_ok_i(vok), .hot_i(hot), .other_dom_i(oth),
        .bus_dom_o(dom), .rxd_o(rxd));
    task automatic chk(input string n, input logic [31:0] s, e);
        n_checks++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch %s exp %0h seen %0h", n, e, s);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        bus <= '{a, v, 1'b1, 1'b0};
        @(posedge clk_i);
        bus <= '0;
        @(posedge clk_i);
    endtask : wr
    task automatic rd(input logic [3:0] a);
        bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk_i);
        bus <= '0;
        #1 d = rdata;
        @(posedge clk_i);
    endtask : rd
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : print_verdict
    task automatic t_modes;
        logic [7:0] c = 8'h9C;
        logic [7:0] x = 8'h1A;
        chk("reset pins", pins, 3'h4);
        for (int k = 0; k < 4; k++) begin
            wr(REG_CTRL, {30'h0, c[2*k+:2]});
            @(negedge clk_i);
            chk("mode", {pins.mode_fast, pins.mode_slope}, x[2*k+:2]);
            @(posedge clk_i);
        end
        $display("done modes");
    endtask : t_modes
    task automatic t_div;
        wr(REG_DIV, 32'h0000_0064);
        rd(REG_DIV);
        chk("div legal", d, 32'h0000_0064);
        wr(REG_DIV, 32'hFFFF_FFFF);
        rd(REG_DIV);
        chk("div max", d, 32'h0000_0619);
        wr(REG_DIV, 32'h0001_0000);
        rd(REG_DIV);
        chk("div wide", d, 32'h0000_0619);
        wr(REG_DIV, 32'h0000_0000);
        rd(REG_DIV);
        chk("div min", d, 32'h0000_0019);
        rd(4'hF);
        chk("unmapped", d, 32'h0000_0000);
        $display("done div");
    endtask : t_div
    task automatic t_frame(input logic [7:0] v, input logic h);
        logic [9:0] f;
        f = {1'b1, v, 1'b0};
        hot <= h;
        wr(REG_CTRL, 32'h0);
        wr(REG_TXDATA, {24'h0, v});
        wr(REG_CTRL, 32'h4);
        // standby request and a second go mid-frame must both be refused
        wr(REG_CTRL, 32'h6);
        for (i = 0; i < 20 && pins.txd; i++) @(negedge clk_i);
        repeat (13) @(negedge clk_i);
        for (int b = 0; b < 10; b++) begin
            chk("txd", pins.txd, f[b]);
            chk("bus", dom, !h && !f[b]);
            repeat (DIV_RESET + 1) @(negedge clk_i);
        end
        @(posedge clk_i);
        for (i = 0; i < 40; i++) begin
            rd(REG_STATUS);
            if (d[ST_BUSY_BIT] === 1'b0) break;
        end
        chk("busy", d[ST_BUSY_BIT], 1'b0);
        rd(REG_RXDATA);
        chk("rx", d, h ? 32'hFF : {24'h0, v});
        chk("mode held", pins.mode_fast, 1'b1);
        rd(REG_TXDATA);
        chk("txbuf", d, {24'h0, v});
        hot <= 1'b0;
        $display("done frame");
    endtask : t_frame
    task automatic t_standby;
        wr(REG_CTRL, 32'h2);
        oth <= 1'b1;
        repeat (4) @(posedge clk_i);
        rd(REG_STATUS);
        chk("activity", d[ST_ACT_BIT], 1'b1);
        chk("stby rxd", d[ST_RX_BIT], 1'b0);
        oth <= 1'b0;
        wr(REG_CTRL, 32'h6);
        repeat (8) @(negedge clk_i);
        chk("stby txd", pins.txd, 1'b1);
        @(posedge clk_i);
        rd(REG_STATUS);
        chk("act sticky", d[ST_ACT_BIT], 1'b1);
        chk("stby go", d[ST_BUSY_BIT], 1'b0);
        rd(REG_STATUS);
        chk("act clear", d[ST_ACT_BIT], 1'b0);
        chk("idle rxd", d[ST_RX_BIT], 1'b1);
        wr(REG_CTRL, 32'h0);
        @(negedge clk_i);
        chk("wake", pins.mode_fast, 1'b1);
        @(posedge clk_i);
        $display("done standby");
    endtask : t_standby
    initial begin
        repeat (8) @(posedge clk_i);
        nrst_i <= 1'b1;
        vok <= 1'b1;
        @(posedge clk_i);
        t_modes;
        t_div;
        t_frame(8'hA5, 1'b0);
        t_frame(8'h3C, 1'b1);
        t_standby;
        print_verdict;
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            print_verdict;
        end
    end
endmodule : tb_top
